// *** shared/ipp_pkg.sv ***
// package: register map, field positions, reset values and carrier types for the arbiter
// How it works
// [R1] writing zero to a timer pending bit clears it; zero read means nothing outstanding
// [R2] a timer pending bit reads one from its event until software clears it
// [R3] pending bits: 3 t1 match, 2 t1 overflow, 1 tA match, 0 tA overflow
// [R4] sixteen-bit instruction pointer split into high and low byte registers
// [R5] priority bits 7,4,1 pick the order of groups A, B and C
// [R6] software never writes group code 000 or 111
// [R7] priority bit 6: zero gives level 6 over 7, one gives 7 over 6
// [R8] priority bit 5: zero gives level 5 over pair 6/7, one the reverse
// [R9] priority bit 3: zero gives level 3 over 4, one gives 4 over 3
// [R10] priority bit 2: zero gives level 2 over 3/4, one the reverse
// [R11] priority bit 0: zero gives level 0 over 1, one gives 1 over 0
// [R12] group A is levels 0-1, B is 2-4, C is 5-7
// [R13] request register is read-only, resets to zero, bit n set while level n pending
package ipp_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  // register offsets
  localparam logic [7:0] OFS_IP_HIGH  = 8'h00da;
  localparam logic [7:0] OFS_IP_LOW   = 8'h00db;
  localparam logic [7:0] OFS_REQUEST  = 8'h00dc;
  localparam logic [7:0] OFS_PRIORITY = 8'h00ff;
  localparam logic [7:0] OFS_PENDING  = 8'h00f9;
  localparam logic [7:0] OFS_STATUS   = 8'h00e0;
  localparam logic [7:0] OFS_MASK     = 8'h00e1;

  // reset values
  localparam logic [7:0] RST_IP_HIGH  = 8'h0000;
  localparam logic [7:0] RST_IP_LOW   = 8'h0000;
  localparam logic [7:0] RST_REQUEST  = 8'h0000;
  localparam logic [7:0] RST_PRIORITY = 8'h0010;
  localparam logic [7:0] RST_MASK     = 8'h0000;
  localparam logic [3:0] RST_PENDING  = 4'h0;

  // pending register fields
  localparam int unsigned PND_T1_MATCH = 3;
  localparam int unsigned PND_T1_OVF   = 2;
  localparam int unsigned PND_TA_MATCH = 1;
  localparam int unsigned PND_TA_OVF   = 0;
  localparam int unsigned PND_W        = 4;

  // priority register fields
  localparam int unsigned PRI_GRP_HI   = 7;
  localparam int unsigned PRI_SUB_C    = 6;
  localparam int unsigned PRI_GRP_C    = 5;
  localparam int unsigned PRI_GRP_MID  = 4;
  localparam int unsigned PRI_SUB_B    = 3;
  localparam int unsigned PRI_GRP_B    = 2;
  localparam int unsigned PRI_GRP_LO   = 1;
  localparam int unsigned PRI_GRP_A    = 0;

  // group order codes from bits 7,4,1
  localparam logic [2:0] ORD_BCA = 3'h1;
  localparam logic [2:0] ORD_ABC = 3'h2;
  localparam logic [2:0] ORD_BAC = 3'h3;
  localparam logic [2:0] ORD_CAB = 3'h4;
  localparam logic [2:0] ORD_CBA = 3'h5;
  localparam logic [2:0] ORD_ACB = 3'h6;

  typedef enum logic [2:0] {
    GRP_A = 3'b001,
    GRP_B = 3'b010,
    GRP_C = 3'b100
  } ipp_grp_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic              wr;
    logic              rd;
  } ipp_bus_t;

  typedef struct packed {
    logic t1_match;
    logic t1_ovf;
    logic ta_match;
    logic ta_ovf;
  } ipp_tmr_evt_t;

  typedef struct packed {
    logic       valid;
    logic [2:0] level;
  } ipp_core_req_t;

endpackage

// *** logic/ipp_sticky_bit.sv ***
// sticky flag: set by hardware, cleared by software, set wins
`timescale 1ns/10ps
`default_nettype none
module ipp_sticky_bit (
  input  wire logic clk,     // system clock
  input  wire logic reset_n, // async reset, active low
  input  wire logic set,     // hardware event
  input  wire logic clr,     // software clear
  output logic      q        // flag state
);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      q <= 1'b0;
    end else if (set) begin
      q <= 1'b1;
    end else if (clr) begin
      q <= 1'b0;
    end
  end

endmodule
`default_nettype wire

// *** logic/ipp_pair_arb.sv ***
// two-way arbiter: picks between a low and a high request under one preference bit
`timescale 1ns/10ps
`default_nettype none
module ipp_pair_arb (
  input  wire logic req_lo,    // request of the first contender
  input  wire logic req_hi,    // request of the second contender
  input  wire logic prefer_hi, // 1: second wins when both ask
  output logic      any,       // either contender asks
  output logic      pick_hi    // second contender wins
);

  assign any     = req_lo | req_hi;
  assign pick_hi = req_hi & (prefer_hi | ~req_lo);

endmodule
`default_nettype wire

// *** logic/ipp_top.sv ***
// interrupt pending, request and priority logic with register port and core request
`timescale 1ns/10ps
`default_nettype none
module ipp_top (
  input  wire logic                  clk,       // system clock, 250 MHz
  input  wire logic                  reset_n,   // async reset, active low
  input  wire ipp_pkg::ipp_bus_t     bus,       // register access from software
  output logic [7:0]                 rdata_q,   // read data, cycle after read strobe
  input  wire ipp_pkg::ipp_tmr_evt_t tmr_evt,   // one-cycle timer event pulses
  input  wire logic [7:0]            lvl_src,   // level requests of other sources
  output ipp_pkg::ipp_core_req_t     core_req_q, // winning level toward the core
  output logic [15:0]                ip_q,      // instruction pointer
  output logic                       irq_q      // level interrupt, high while unmasked status
);

  logic [7:0]                  ip_high_q;
  logic [7:0]                  ip_low_q;
  logic [7:0]                  prio_q;
  logic [7:0]                  mask_q;
  logic [7:0]                  req_flags_q;
  logic [7:0]                  req_flags_d;
  logic [ipp_pkg::PND_W-1:0]   pend;
  logic [ipp_pkg::PND_W-1:0]   pend_set;
  logic [ipp_pkg::PND_W-1:0]   pend_clr;
  logic [7:0]                  stat;
  logic [7:0]                  stat_set;
  logic                        stat_clr;
  logic                        wr_pend;
  logic [7:0]                  rdata_d;
  ipp_pkg::ipp_core_req_t      core_req_d;

  logic                        a_any;
  logic                        a_hi;
  logic                        bs_any;
  logic                        bs_hi;
  logic                        b_any;
  logic                        b_hi;
  logic                        cs_any;
  logic                        cs_hi;
  logic                        c_any;
  logic                        c_hi;
  logic [2:0]                  a_lvl;
  logic [2:0]                  b_lvl;
  logic [2:0]                  c_lvl;
  logic [2:0]                  grp_code;
  ipp_pkg::ipp_grp_t           first;
  ipp_pkg::ipp_grp_t           second;
  ipp_pkg::ipp_grp_t           third;
  ipp_pkg::ipp_grp_t           win_grp;
  logic                        win_any;

  // ---------------- software writes ----------------

  // instruction pointer bytes
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ip_high_q <= ipp_pkg::RST_IP_HIGH;
      ip_low_q  <= ipp_pkg::RST_IP_LOW;
    end else if (bus.wr) begin
      if (bus.addr == ipp_pkg::OFS_IP_HIGH) begin
        ip_high_q <= bus.wdata; // [R4]
      end
      if (bus.addr == ipp_pkg::OFS_IP_LOW) begin
        ip_low_q <= bus.wdata; // [R4]
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ip_q <= {ipp_pkg::RST_IP_HIGH, ipp_pkg::RST_IP_LOW};
    end else begin
      ip_q <= {ip_high_q, ip_low_q}; // [R4]
    end
  end

  // priority control; codes 000 and 111 are stored as written, software keeps away from them
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      prio_q <= ipp_pkg::RST_PRIORITY;
    end else if (bus.wr && bus.addr == ipp_pkg::OFS_PRIORITY) begin
      prio_q <= bus.wdata;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_q <= ipp_pkg::RST_MASK;
    end else if (bus.wr && bus.addr == ipp_pkg::OFS_MASK) begin
      mask_q <= bus.wdata;
    end
  end

  // ---------------- timer pending flags ----------------

  assign wr_pend = bus.wr && (bus.addr == ipp_pkg::OFS_PENDING);

  assign pend_set[ipp_pkg::PND_T1_MATCH] = tmr_evt.t1_match; // [R3]
  assign pend_set[ipp_pkg::PND_T1_OVF]   = tmr_evt.t1_ovf;   // [R3]
  assign pend_set[ipp_pkg::PND_TA_MATCH] = tmr_evt.ta_match; // [R3]
  assign pend_set[ipp_pkg::PND_TA_OVF]   = tmr_evt.ta_ovf;   // [R3]

  // a one written leaves the flag alone, so software can clear one source without racing others
  assign pend_clr = {ipp_pkg::PND_W{wr_pend}} & ~bus.wdata[ipp_pkg::PND_W-1:0]; // [R1]

  genvar gi;
  generate
    for (gi = 0; gi < ipp_pkg::PND_W; gi++) begin : g_pend
      ipp_sticky_bit u_pend (
        .clk     (clk),
        .reset_n (reset_n),
        .set     (pend_set[gi]),
        .clr     (pend_clr[gi]),
        .q       (pend[gi])
      ); // [R2]
    end
  endgenerate

  // ---------------- level requests ----------------

  // timer levels follow their pending flags, the rest come from their own sources
  always_comb begin
    req_flags_d    = lvl_src;
    req_flags_d[3] = pend[ipp_pkg::PND_T1_MATCH] | pend[ipp_pkg::PND_T1_OVF]; // [R13]
    req_flags_d[0] = pend[ipp_pkg::PND_TA_MATCH] | pend[ipp_pkg::PND_TA_OVF]; // [R13]
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      req_flags_q <= ipp_pkg::RST_REQUEST; // [R13]
    end else begin
      req_flags_q <= req_flags_d;
    end
  end

  // ---------------- arbitration ----------------

  ipp_pair_arb u_grp_a (
    .req_lo    (req_flags_q[0]),
    .req_hi    (req_flags_q[1]),
    .prefer_hi (prio_q[ipp_pkg::PRI_GRP_A]), // [R11]
    .any       (a_any),
    .pick_hi   (a_hi)
  );

  ipp_pair_arb u_sub_b (
    .req_lo    (req_flags_q[3]),
    .req_hi    (req_flags_q[4]),
    .prefer_hi (prio_q[ipp_pkg::PRI_SUB_B]), // [R9]
    .any       (bs_any),
    .pick_hi   (bs_hi)
  );

  ipp_pair_arb u_grp_b (
    .req_lo    (req_flags_q[2]),
    .req_hi    (bs_any),
    .prefer_hi (prio_q[ipp_pkg::PRI_GRP_B]), // [R10]
    .any       (b_any),
    .pick_hi   (b_hi)
  );

  ipp_pair_arb u_sub_c (
    .req_lo    (req_flags_q[6]),
    .req_hi    (req_flags_q[7]),
    .prefer_hi (prio_q[ipp_pkg::PRI_SUB_C]), // [R7]
    .any       (cs_any),
    .pick_hi   (cs_hi)
  );

  ipp_pair_arb u_grp_c (
    .req_lo    (req_flags_q[5]),
    .req_hi    (cs_any),
    .prefer_hi (prio_q[ipp_pkg::PRI_GRP_C]), // [R8]
    .any       (c_any),
    .pick_hi   (c_hi)
  );

  // group membership of the levels
  assign a_lvl = a_hi ? 3'h1 : 3'h0;                      // [R12]
  assign b_lvl = b_hi ? (bs_hi ? 3'h4 : 3'h3) : 3'h2;     // [R12]
  assign c_lvl = c_hi ? (cs_hi ? 3'h7 : 3'h6) : 3'h5;     // [R12]

  assign grp_code = {prio_q[ipp_pkg::PRI_GRP_HI], prio_q[ipp_pkg::PRI_GRP_MID],
                     prio_q[ipp_pkg::PRI_GRP_LO]};

  // undefined codes fall back to A>B>C so the core never sees a stalled arbiter
  always_comb begin
    first  = ipp_pkg::GRP_A;
    second = ipp_pkg::GRP_B;
    third  = ipp_pkg::GRP_C;
    case (grp_code)
      ipp_pkg::ORD_BCA: begin
        first  = ipp_pkg::GRP_B;
        second = ipp_pkg::GRP_C;
        third  = ipp_pkg::GRP_A;
      end
      ipp_pkg::ORD_BAC: begin
        first  = ipp_pkg::GRP_B;
        second = ipp_pkg::GRP_A;
        third  = ipp_pkg::GRP_C;
      end
      ipp_pkg::ORD_CAB: begin
        first  = ipp_pkg::GRP_C;
        second = ipp_pkg::GRP_A;
        third  = ipp_pkg::GRP_B;
      end
      ipp_pkg::ORD_CBA: begin
        first  = ipp_pkg::GRP_C;
        second = ipp_pkg::GRP_B;
        third  = ipp_pkg::GRP_A;
      end
      ipp_pkg::ORD_ACB: begin
        first  = ipp_pkg::GRP_A;
        second = ipp_pkg::GRP_C;
        third  = ipp_pkg::GRP_B;
      end
      default: begin
        first  = ipp_pkg::GRP_A;
        second = ipp_pkg::GRP_B;
        third  = ipp_pkg::GRP_C;
      end
    endcase
  end // [R5] [R6]

  function automatic logic grp_any(input ipp_pkg::ipp_grp_t g, input logic aa,
                                   input logic ba, input logic ca);
    grp_any = (g == ipp_pkg::GRP_A) ? aa : ((g == ipp_pkg::GRP_B) ? ba : ca);
  endfunction

  always_comb begin
    win_any = 1'b1;
    if (grp_any(first, a_any, b_any, c_any)) begin
      win_grp = first; // [R5]
    end else if (grp_any(second, a_any, b_any, c_any)) begin
      win_grp = second; // [R5]
    end else begin
      win_grp = third;
      win_any = grp_any(third, a_any, b_any, c_any);
    end
  end

  always_comb begin
    core_req_d.valid = win_any;
    unique case (win_grp)
      ipp_pkg::GRP_A: core_req_d.level = a_lvl;
      ipp_pkg::GRP_B: core_req_d.level = b_lvl;
      ipp_pkg::GRP_C: core_req_d.level = c_lvl;
      default:        core_req_d.level = 3'h0;
    endcase
    if (!win_any) begin
      core_req_d.level = 3'h0;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      core_req_q <= '0;
    end else begin
      core_req_q <= core_req_d;
    end
  end

  // ---------------- event status and interrupt line ----------------

  // a level becoming pending is the event; read of status clears, a new event in that cycle wins
  assign stat_set = req_flags_d & ~req_flags_q;
  assign stat_clr = bus.rd && (bus.addr == ipp_pkg::OFS_STATUS);

  generate
    for (gi = 0; gi < 8; gi++) begin : g_stat
      ipp_sticky_bit u_stat (
        .clk     (clk),
        .reset_n (reset_n),
        .set     (stat_set[gi]),
        .clr     (stat_clr),
        .q       (stat[gi])
      );
    end
  endgenerate

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(stat & mask_q);
    end
  end

  // ---------------- read port ----------------

  always_comb begin
    rdata_d = 8'h0000;
    unique case (bus.addr)
      ipp_pkg::OFS_IP_HIGH:  rdata_d = ip_high_q;                        // [R4]
      ipp_pkg::OFS_IP_LOW:   rdata_d = ip_low_q;                         // [R4]
      ipp_pkg::OFS_REQUEST:  rdata_d = req_flags_q;                      // [R13]
      ipp_pkg::OFS_PRIORITY: rdata_d = prio_q;
      ipp_pkg::OFS_PENDING:  rdata_d = {4'h0, pend};                     // [R1] [R2]
      ipp_pkg::OFS_STATUS:   rdata_d = stat;
      ipp_pkg::OFS_MASK:     rdata_d = mask_q;
      default:               rdata_d = 8'h0000;
    endcase
  end

  // data only stand in the cycle after the strobe; zero otherwise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_q <= 8'h0000;
    end else if (bus.rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h0000;
    end
  end

endmodule
`default_nettype wire

// *** tb/ipp_top_asserts.sv ***
// checker: port-level assertions for the pending and priority logic
`timescale 1ns/10ps
`default_nettype none
module ipp_top_asserts (
  input wire logic                   clk,        // system clock
  input wire logic                   reset_n,    // async reset, active low
  input wire ipp_pkg::ipp_bus_t      bus,        // register access
  input wire logic [7:0]             rdata_q,    // read data
  input wire ipp_pkg::ipp_tmr_evt_t  tmr_evt,    // timer events
  input wire logic [7:0]             lvl_src,    // level sources
  input wire ipp_pkg::ipp_core_req_t core_req_q, // core request
  input wire logic [15:0]            ip_q,       // instruction pointer
  input wire logic                   irq_q       // interrupt
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [3:0] pnd_q;
  logic [7:0] pri_q;
  logic [2:0] up_q;
  logic [7:0] req_c;
  // shadows of pending and priority, so the arbiter is judged from bus, timer event and level source traffic alone
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) pnd_q <= ipp_pkg::RST_PENDING;
    else if (bus.wr && bus.addr == ipp_pkg::OFS_PENDING) pnd_q <= 4'(tmr_evt) | (pnd_q & bus.wdata[3:0]);
    else pnd_q <= 4'(tmr_evt) | pnd_q;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) pri_q <= ipp_pkg::RST_PRIORITY;
    else if (bus.wr && bus.addr == ipp_pkg::OFS_PRIORITY) pri_q <= bus.wdata;
  end
  // history from before release is not trusted
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) up_q <= 3'h0;
    else up_q <= {up_q[1:0], 1'b1};
  end
  assign req_c = {lvl_src[7:4], pnd_q[3] | pnd_q[2], lvl_src[2:1], pnd_q[1] | pnd_q[0]};
  function automatic logic [2:0] first(input logic [2:0] c);
    case (c)
      3'h1, 3'h3: return 3'h2;
      3'h4, 3'h5: return 3'h5;
      default: return 3'h0;
    endcase
  endfunction
  property p_win(logic [7:0] pat, logic [2:0] lvl);
    up_q[2] && $past(req_c, 2) == pat |-> core_req_q.level == lvl;
  endproperty
  a_ip_high_wr: assert property (bus.wr && bus.addr == ipp_pkg::OFS_IP_HIGH |=>
    ##1 ip_q[15:8] == $past(bus.wdata, 2)) else $error("ip high byte not loaded");
  a_ip_low_wr: assert property (bus.wr && bus.addr == ipp_pkg::OFS_IP_LOW |=>
    ##1 ip_q[7:0] == $past(bus.wdata, 2)) else $error("ip low byte not loaded");
  a_valid_any: assert property (up_q[2] |-> core_req_q.valid == |$past(req_c, 2))
    else $error("core request valid wrong");
  a_sub_c_order: assert property (p_win(8'hc0, $past(pri_q[6]) ? 3'h7 : 3'h6))
    else $error("level six or seven order wrong");
  a_grp_c_order: assert property (p_win(8'h60, $past(pri_q[5]) ? 3'h6 : 3'h5))
    else $error("level five against pair wrong");
  a_sub_b_order: assert property (p_win(8'h18, $past(pri_q[3]) ? 3'h4 : 3'h3))
    else $error("level three or four order wrong");
  a_grp_b_order: assert property (p_win(8'h14, $past(pri_q[2]) ? 3'h4 : 3'h2))
    else $error("level two against pair wrong");
  a_grp_a_order: assert property (p_win(8'h03, $past(pri_q[0]) ? 3'h1 : 3'h0))
    else $error("level zero or one order wrong");
  a_group_order: assert property (p_win(8'h25, first({$past(pri_q[7]),
    $past(pri_q[4]), $past(pri_q[1])}))) else $error("group order wrong");
  a_pend_read: assert property (bus.rd && bus.addr == ipp_pkg::OFS_PENDING |=>
    rdata_q == {4'h0, $past(pnd_q)}) else $error("pending read data wrong");
  a_req_read: assert property (bus.rd && bus.addr == ipp_pkg::OFS_REQUEST |=>
    rdata_q == $past(req_c, 2)) else $error("request read data wrong");
  // read data must drop back to zero so a stale value is never taken as an answer
  a_rdata_idle: assert property (!$past(bus.rd) |-> rdata_q == 8'h00)
    else $error("read data not zero outside read");
  c_core_req: cover property (core_req_q.valid);
  c_irq: cover property (irq_q);
  c_pri_wr: cover property (bus.wr && bus.addr == ipp_pkg::OFS_PRIORITY);
endmodule
`default_nettype wire

// *** tb/ipp_core_model.sv ***
// core model: takes the winning level the arbiter offers
`timescale 1ns/10ps
`default_nettype none
module ipp_core_model (
  input  wire logic                   clk,      // system clock
  input  wire logic                   reset_n,  // async reset, active low
  input  wire ipp_pkg::ipp_core_req_t core_req, // request from the arbiter
  output ipp_pkg::ipp_core_req_t      seen_q    // request as last taken
);
  // one sample a cycle: a request shorter than a cycle would be missed, as in the core
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) seen_q <= '0;
    else seen_q <= core_req;
  end
endmodule
`default_nettype wire

// *** tb/interrupt_priority_pending_tb.sv ***
// testbench: register, pending, interrupt and arbitration scenarios
`timescale 1ns/10ps
`default_nettype none
module interrupt_priority_pending_tb;
  logic                   clk;
  logic                   reset_n;
  ipp_pkg::ipp_bus_t      bus;
  ipp_pkg::ipp_tmr_evt_t  tmr_evt;
  logic [7:0]             lvl_src;
  logic [7:0]             rdata_q;
  ipp_pkg::ipp_core_req_t core_req_q;
  ipp_pkg::ipp_core_req_t seen;
  logic [15:0]            ip_q;
  logic                   irq_q;
  int                     n_mismatch;
  int                     n_tests;
  int                     cyc;
  logic [7:0]             pats [9];

  ipp_top i_dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata_q(rdata_q),
    .tmr_evt(tmr_evt), .lvl_src(lvl_src), .core_req_q(core_req_q), .ip_q(ip_q),
    .irq_q(irq_q));
  ipp_core_model i_core (.clk(clk), .reset_n(reset_n), .core_req(core_req_q), .seen_q(seen));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      n_mismatch++;
      print_verdict();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    bus <= '{a, d, 1'b1, 1'b0};
    @(posedge clk);
    bus <= '0;
  endtask
  // read data stand only in the cycle after the strobe, so look there
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk);
    bus <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge clk);
    bus <= '0;
    #1;
    chk(16'(rdata_q), 16'(exp));
  endtask
  task automatic evt(input ipp_pkg::ipp_tmr_evt_t b);
    @(posedge clk);
    tmr_evt <= b;
    @(posedge clk);
    tmr_evt <= '0;
  endtask

  function automatic logic [2:0] win(input logic [7:0] r, input logic [7:0] p);
    logic [2:0] lv [3];
    logic [5:0] ord;
    logic [1:0] g;
    lv[0] = (r[1] && (p[0] || !r[0])) ? 3'h1 : 3'h0;
    lv[1] = (r[4] && (p[3] || !r[3])) ? 3'h4 : 3'h3;
    if (r[2] && (!(r[3] | r[4]) || !p[2])) lv[1] = 3'h2;
    lv[2] = (r[7] && (p[6] || !r[6])) ? 3'h7 : 3'h6;
    if (r[5] && (!(r[6] | r[7]) || !p[5])) lv[2] = 3'h5;
    case ({p[7], p[4], p[1]})
      3'h1: ord = 6'b01_10_00;
      3'h3: ord = 6'b01_00_10;
      3'h4: ord = 6'b10_00_01;
      3'h5: ord = 6'b10_01_00;
      3'h6: ord = 6'b00_10_01;
      default: ord = 6'b00_01_10;
    endcase
    for (int i = 0; i < 3; i++) begin
      g = ord[5 - 2 * i -: 2];
      if ((g == 2'd0 && |r[1:0]) || (g == 2'd1 && |r[4:2]) || (g == 2'd2 && |r[7:5])) return lv[g];
    end
    return 3'h0;
  endfunction

  initial begin
    bus = '0;
    tmr_evt = '0;
    lvl_src = 8'h00;
    reset_n = 1'b0;
    n_mismatch = 0;
    n_tests = 0;
    pats = '{8'hff, 8'hc0, 8'h18, 8'h03, 8'h14, 8'h60, 8'h25, 8'h9a, 8'h00};
    repeat (20) @(posedge clk);
    reset_n <= 1'b1;
    tick(1);
    chk(16'(core_req_q), 16'h0000);
    rd(ipp_pkg::OFS_REQUEST, ipp_pkg::RST_REQUEST);
    rd(ipp_pkg::OFS_PRIORITY, ipp_pkg::RST_PRIORITY);
    wr(ipp_pkg::OFS_REQUEST, 8'hff);
    rd(ipp_pkg::OFS_REQUEST, 8'h00);
    rd(8'h10, 8'h00);
    wr(ipp_pkg::OFS_IP_HIGH, 8'ha5);
    wr(ipp_pkg::OFS_IP_LOW, 8'h3c);
    rd(ipp_pkg::OFS_IP_HIGH, 8'ha5);
    rd(ipp_pkg::OFS_IP_LOW, 8'h3c);
    chk(ip_q, 16'ha53c);
    for (int i = 0; i < 4; i++) begin
      evt(4'(1 << i));
      wr(ipp_pkg::OFS_PENDING, 8'hff);
      rd(ipp_pkg::OFS_PENDING, 8'(1 << i));
      rd(ipp_pkg::OFS_REQUEST, (i > 1) ? 8'h08 : 8'h01);
      wr(ipp_pkg::OFS_PENDING, ~8'(1 << i));
      rd(ipp_pkg::OFS_PENDING, 8'h00);
    end
    tick(3);
    rd(ipp_pkg::OFS_STATUS, 8'h09);
    rd(ipp_pkg::OFS_STATUS, 8'h00);
    wr(ipp_pkg::OFS_MASK, 8'h01);
    evt(4'h2);
    tick(3);
    chk(16'(irq_q), 16'h0001);
    rd(ipp_pkg::OFS_STATUS, 8'h01);
    tick(2);
    chk(16'(irq_q), 16'h0000);
    wr(ipp_pkg::OFS_PENDING, 8'h00);
    evt(4'h8);
    tick(4);
    chk(16'(irq_q), 16'h0000);
    wr(ipp_pkg::OFS_PENDING, 8'h00);
    // event and clearing write in one cycle: the event must survive
    @(posedge clk);
    tmr_evt <= 4'h1;
    bus <= '{ipp_pkg::OFS_PENDING, 8'h00, 1'b1, 1'b0};
    @(posedge clk);
    tmr_evt <= '0;
    bus <= '0;
    rd(ipp_pkg::OFS_PENDING, 8'h01);
    wr(ipp_pkg::OFS_PENDING, 8'h00);
    rd(ipp_pkg::OFS_PENDING, 8'h00);
    for (int p = 0; p < 256; p++) begin
      if (p[7] == p[4] && p[4] == p[1]) continue;
      wr(ipp_pkg::OFS_PRIORITY, 8'(p));
      foreach (pats[k]) begin
        @(posedge clk);
        lvl_src <= pats[k] | 8'h09;
        evt({1'b0, pats[k][3], 1'b0, pats[k][0]});
        tick(4);
        chk(16'(seen), 16'({|pats[k], win(pats[k], 8'(p))}));
        wr(ipp_pkg::OFS_PENDING, 8'h00);
      end
    end
    print_verdict();
  end
endmodule

bind ipp_top ipp_top_asserts i_chk (.clk(clk), .reset_n(reset_n), .bus(bus),
  .rdata_q(rdata_q), .tmr_evt(tmr_evt), .lvl_src(lvl_src), .core_req_q(core_req_q),
  .ip_q(ip_q), .irq_q(irq_q));
`default_nettype wire
